// ==== verilog/usb_in_ep_pkg.sv ====
// Constants, register map and carrier types for the IN endpoint control block
package usb_in_ep_pkg;

   // =========================================================
   // Register indices (byte address = index * 4)
   localparam logic [5:0] IDX_CTRL_LOW = 6'h11;
   localparam logic [5:0] IDX_CTRL_HIGH = 6'h12;
   localparam logic [5:0] IDX_AUX_CTRL = 6'h13;
   localparam logic [5:0] IDX_STATUS = 6'h14;

   // =========================================================
   // Low control byte fields
   localparam int LOW_READY = 0;
   localparam int LOW_NOT_EMPTY = 1;
   localparam int LOW_UNDERRUN = 2;
   localparam int LOW_PURGE = 3;
   localparam int LOW_TOGGLE_RESET = 6;

   // =========================================================
   // High control byte fields
   localparam int HIGH_DOUBLE_BUF = 7;
   localparam int HIGH_ISO = 6;
   localparam int HIGH_DIR = 5;
   localparam int HIGH_FORCED_TOGGLE = 3;
   localparam int HIGH_SPLIT = 2;
   localparam logic [7:0] HIGH_WRITE_MASK = 8'hEC;

   // =========================================================
   // Auxiliary control fields
   localparam int AUX_ISO_UPDATE_HOLD = 0;
   localparam int AUX_IRQ_EN = 1;

   // =========================================================
   // Reset values and sizes
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] AUX_RESET = 2'h0;
   localparam logic [1:0] SLOTS_SINGLE = 2'h1;
   localparam logic [1:0] SLOTS_DOUBLE = 2'h2;
   localparam int PURGE_CYCLES = 1;

   // =========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT_ACK = 3'b010,
      ST_PURGE = 3'b100
   } ep_state_t;

   typedef struct packed {
      logic inToken;
      logic sof;
      logic hostAck;
      logic hostTimeout;
   } link_evt_t;

   typedef struct packed {
      logic sendData;
      logic sendZeroLen;
      logic sendNak;
   } link_cmd_t;

endpackage

// ==== verilog/pkt_slot_counter.sv ====
// Counts packets held in the IN endpoint FIFO
`timescale 1ns/1ps
`default_nettype none
module pkt_slot_counter
   import usb_in_ep_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic unload,
   input wire logic [1:0] capacity,
   output logic [1:0] count,
   output logic notEmpty
);

   // =========================================================
   // Counter
   // Load past capacity is dropped; the flag logic asks for it only after double buffering is switched off with packets held
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count <= 2'h0;
      end else if (load && !unload && count < capacity) begin
         count <= count + 2'h1;
      end else if (unload && !load && count != 2'h0) begin
         count <= count - 2'h1;
      end
   end

   assign notEmpty = (count != 2'h0);

endmodule
`default_nettype wire

// ==== verilog/usb_in_endpoint_control.sv ====
// IN endpoint control and status logic with a classic Wishbone register slave
//
// What this block does
// RL1 - Purge write discards next pending packet
// RL2 - Purge resets FIFO pointer, clears ready
// RL3 - Firmware purges each packet separately
// RL4 - Purge bit self-clears when purge completes
// RL5 - Iso underrun sends zero-length, sets underrun
// RL6 - Bulk underrun NAKs, flags; firmware clears
// RL7 - Not-empty reads one while packets held
// RL8 - Firmware sets ready after loading packet
// RL9 - Ready clears once packet is transmitted
// RL10 - Double buffering frees ready when slot opens
// RL11 - Iso hold: ready reads zero until SOF
// RL12 - Transmit-clear of ready raises enabled interrupt
// RL13 - Double-buffer bit selects one or two slots
// RL14 - Transfer-type bit selects bulk or isochronous
// RL15 - Direction bit applies only when unsplit
// RL16 - Unforced toggle advances only after ACK
// RL17 - Forced toggle advances on every send
// RL18 - Split gives upper half IN, lower OUT
// RL19 - Unused high bits read zero, ignore writes
// RL20 - Toggle reset bit zeroes toggle, reads zero
// RL21 - Control bytes reset to all zeros
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module usb_in_endpoint_control
   import usb_in_ep_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire link_evt_t linkEvt,
   output link_cmd_t linkCmd,
   output logic dataToggle,
   output logic epIrq,
   output logic fifoPtrReset,
   output logic fifoSplit,
   output logic endpointIsIn,
   output logic inUpperHalf,
   output logic outLowerHalf
);

   // =========================================================
   // Bus decode
   logic busReq;
   logic wrStrobe;
   logic [5:0] wordIdx;
   logic lane0;

   assign busReq = cyc_i && stb_i;
   assign wordIdx = adr_i[7:2];
   assign lane0 = sel_i[0];
   // Write lands on the edge where the master sees ack
   assign wrStrobe = busReq && we_i && ack_o && lane0;

   function automatic logic wrBit(input logic [5:0] idx, input int pos);
      wrBit = wrStrobe && wordIdx == idx && dat_i[pos];
   endfunction

   function automatic logic wrZero(input logic [5:0] idx, input int pos);
      wrZero = wrStrobe && wordIdx == idx && !dat_i[pos];
   endfunction

   // =========================================================
   // Control state
   logic [7:0] ctrlHigh;
   logic [1:0] auxCtrl;
   logic readyFlag;
   logic underrun;
   logic purgeBit;
   logic isoWaitSof;
   ep_state_t state;

   logic doubleBuf;
   logic isoMode;
   logic forcedToggle;
   logic splitOn;
   logic isoHoldOn;
   logic irqEn;

   assign doubleBuf = ctrlHigh[HIGH_DOUBLE_BUF]; // RL13
   assign isoMode = ctrlHigh[HIGH_ISO]; // RL14
   assign forcedToggle = ctrlHigh[HIGH_FORCED_TOGGLE];
   assign splitOn = ctrlHigh[HIGH_SPLIT];
   assign isoHoldOn = auxCtrl[AUX_ISO_UPDATE_HOLD];
   assign irqEn = auxCtrl[AUX_IRQ_EN];

   // =========================================================
   // Packet slots
   logic [1:0] pktCount;
   logic notEmpty;
   logic [1:0] capacity;
   logic commit;
   logic unload;
   logic purgeStep;
   logic txDone;
   logic eligible;
   logic isIdle;

   assign capacity = doubleBuf ? SLOTS_DOUBLE : SLOTS_SINGLE; // RL13
   // Ready written while already set is a no-op: no slot to take it
   assign commit = wrBit(IDX_CTRL_LOW, LOW_READY) && !readyFlag; // RL8
   assign isIdle = (state == ST_IDLE);
   // Packet is not offered before the next SOF in iso hold mode
   assign eligible = notEmpty && !isoWaitSof; // RL11
   assign purgeStep = (state == ST_PURGE);

   // Transmit is complete at the send in iso mode, at the ACK otherwise
   always_comb begin
      txDone = 1'b0;
      // A pending purge takes the packet, so an iso token must not unload it too
      if (isIdle && !purgeBit && linkEvt.inToken && eligible && isoMode) begin
         txDone = 1'b1;
      end else if (state == ST_WAIT_ACK && linkEvt.hostAck) begin
         txDone = 1'b1;
      end
   end

   assign unload = txDone || (purgeStep && notEmpty); // RL1

   pkt_slot_counter slots (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load(commit),
      .unload(unload),
      .capacity(capacity),
      .count(pktCount),
      .notEmpty(notEmpty)
   );

   // =========================================================
   // High control byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrlHigh <= CTRL_RESET; // RL21
      end else if (wrStrobe && wordIdx == IDX_CTRL_HIGH) begin
         ctrlHigh <= dat_i[7:0] & HIGH_WRITE_MASK; // RL19
      end
   end

   // =========================================================
   // Auxiliary control
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         auxCtrl <= AUX_RESET;
      end else if (wrStrobe && wordIdx == IDX_AUX_CTRL) begin
         auxCtrl <= dat_i[1:0];
      end
   end

   // =========================================================
   // Packet ready flag
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         readyFlag <= 1'b0; // RL21
      end else if (commit) begin
         readyFlag <= 1'b1; // RL8
      end else if (txDone || purgeStep) begin
         readyFlag <= 1'b0; // RL9 RL2
      end else if (doubleBuf && pktCount < SLOTS_DOUBLE) begin
         readyFlag <= 1'b0; // RL10
      end
   end

   // =========================================================
   // Iso update hold
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         isoWaitSof <= 1'b0;
      end else if (commit && isoMode && isoHoldOn) begin
         isoWaitSof <= 1'b1; // RL11
      end else if (linkEvt.sof || !isoMode || purgeStep) begin
         isoWaitSof <= 1'b0;
      end
   end

   // =========================================================
   // Underrun flag
   // Hardware set wins over a firmware clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         underrun <= 1'b0;
      end else if (isIdle && linkEvt.inToken && !eligible) begin
         underrun <= 1'b1; // RL5 RL6
      end else if (wrZero(IDX_CTRL_LOW, LOW_UNDERRUN)) begin
         underrun <= 1'b0; // RL6
      end
   end

   // =========================================================
   // Purge request
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         purgeBit <= 1'b0;
      end else if (wrBit(IDX_CTRL_LOW, LOW_PURGE)) begin
         purgeBit <= 1'b1; // RL1
      end else if (purgeStep) begin
         purgeBit <= 1'b0; // RL4
      end
   end

   // =========================================================
   // Endpoint sequencer
   // A purge waits out a packet in flight so the FIFO is not cut mid-send
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (purgeBit) begin
                  state <= ST_PURGE; // RL1
               end else if (linkEvt.inToken && eligible && !isoMode) begin
                  state <= ST_WAIT_ACK;
               end
            end
            ST_WAIT_ACK: begin
               if (linkEvt.hostAck || linkEvt.hostTimeout) begin
                  state <= ST_IDLE;
               end
            end
            ST_PURGE: begin
               state <= ST_IDLE; // RL4
            end
         endcase
      end
   end

   // =========================================================
   // Link answers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         linkCmd <= '0;
      end else begin
         linkCmd.sendData <= isIdle && !purgeBit && linkEvt.inToken && eligible;
         linkCmd.sendZeroLen <= isIdle && linkEvt.inToken && !eligible && isoMode; // RL5
         linkCmd.sendNak <= isIdle && linkEvt.inToken && !eligible && !isoMode; // RL6
      end
   end

   // =========================================================
   // Data toggle
   logic sentNow;
   assign sentNow = isIdle && !purgeBit && linkEvt.inToken && eligible;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dataToggle <= 1'b0;
      end else if (wrBit(IDX_CTRL_LOW, LOW_TOGGLE_RESET)) begin
         dataToggle <= 1'b0; // RL20
      end else if (forcedToggle && sentNow) begin
         dataToggle <= !dataToggle; // RL17
      end else if (!forcedToggle && state == ST_WAIT_ACK && linkEvt.hostAck) begin
         dataToggle <= !dataToggle; // RL16
      end
   end

   // =========================================================
   // Interrupt and FIFO pointer pulses
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         epIrq <= 1'b0;
         fifoPtrReset <= 1'b0;
      end else begin
         epIrq <= txDone && readyFlag && irqEn; // RL12
         fifoPtrReset <= purgeStep; // RL2
      end
   end

   // =========================================================
   // FIFO arrangement
   // Split forces the IN role; direction bit is ignored meanwhile
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fifoSplit <= 1'b0;
         endpointIsIn <= 1'b0;
         inUpperHalf <= 1'b0;
         outLowerHalf <= 1'b0;
      end else begin
         fifoSplit <= splitOn; // RL18
         endpointIsIn <= splitOn ? 1'b1 : ctrlHigh[HIGH_DIR]; // RL15
         inUpperHalf <= splitOn; // RL18
         outLowerHalf <= splitOn; // RL18
      end
   end

   // =========================================================
   // Read mux
   logic [7:0] lowView;
   logic [31:0] readWord;

   always_comb begin
      lowView = 8'h00;
      lowView[LOW_READY] = readyFlag && !isoWaitSof; // RL11
      lowView[LOW_NOT_EMPTY] = notEmpty; // RL7
      lowView[LOW_UNDERRUN] = underrun;
      lowView[LOW_PURGE] = purgeBit;
      readWord = 32'h0000_0000;
      unique case (wordIdx)
         IDX_CTRL_LOW: readWord[7:0] = lowView; // RL20
         IDX_CTRL_HIGH: readWord[7:0] = ctrlHigh; // RL19
         IDX_AUX_CTRL: readWord[1:0] = auxCtrl;
         IDX_STATUS: readWord[5:0] = {state, pktCount, dataToggle};
         default: readWord = 32'h0000_0000;
      endcase
   end

   // =========================================================
   // Wishbone answer
   // One wait state: ack in the cycle after the request, dropped after one
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= busReq && !ack_o;
         dat_o <= (busReq && !we_i && !ack_o) ? readWord : 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

// ==== verif/usb_in_ep_props.sv ====
// Port assertions for the IN endpoint control block
`timescale 1ns/1ps
`default_nettype none
module usb_in_ep_props
   import usb_in_ep_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire link_evt_t linkEvt,
   input wire link_cmd_t linkCmd,
   input wire logic dataToggle,
   input wire logic epIrq,
   input wire logic fifoPtrReset,
   input wire logic fifoSplit,
   input wire logic endpointIsIn,
   input wire logic inUpperHalf,
   input wire logic outLowerHalf
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Bus answer
   ack_pulse_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack is not a one-cycle answer");
   read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   // ==========
   // Link and endpoint
   cmd_single_a: assert property ($onehot0(linkCmd))
      else $error("more than one link answer");
   cmd_cause_a: assert property (|linkCmd |-> $past(linkEvt.inToken))
      else $error("link answer without token");
   split_half_a: assert property (inUpperHalf == fifoSplit && outLowerHalf == fifoSplit)
      else $error("split halves disagree");
   split_dir_a: assert property (fifoSplit |-> endpointIsIn)
      else $error("split endpoint not IN");
   irq_cause_a: assert property (epIrq |-> linkCmd.sendData || $past(linkEvt.hostAck))
      else $error("interrupt without transmit");
   toggle_cause_a: assert property ($changed(dataToggle)
      |-> linkCmd.sendData || $past(linkEvt.hostAck) || $past(ack_o))
      else $error("toggle changed without cause");
   purge_pulse_a: assert property (fifoPtrReset |=> !fifoPtrReset)
      else $error("pointer reset longer than one cycle");
   cover property (linkCmd.sendZeroLen);
   cover property (linkCmd.sendNak);
   cover property (epIrq);
   cover property (fifoPtrReset);
endmodule
bind usb_in_endpoint_control usb_in_ep_props props_u (.core_clk, .rst_n, .cyc_i, .stb_i,
   .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .linkEvt, .linkCmd, .dataToggle,
   .epIrq, .fifoPtrReset, .fifoSplit, .endpointIsIn, .inUpperHalf, .outLowerHalf);
`default_nettype wire

// ==== verif/usb_host_model.sv ====
// Host model issuing IN tokens, SOF and bulk handshakes
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
   import usb_in_ep_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tokReq,
   input wire logic sofReq,
   input wire logic isoMode,
   input wire logic tmoMode,
   input wire logic [3:0] ackDelay,
   input wire link_cmd_t linkCmd,
   output var link_evt_t linkEvt,
   output logic busy
);
   // ==========
   // Handshake timing
   logic [4:0] remain;
   // Iso data gets no handshake, so only bulk data waits
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         remain <= 5'h00;
      end else if (linkCmd.sendData && !isoMode) begin
         remain <= {1'b0, ackDelay} + 5'h01;
      end else if (remain != 5'h00) begin
         remain <= remain - 5'h01;
      end
   end
   assign busy = remain != 5'h00;
   assign linkEvt.inToken = tokReq;
   assign linkEvt.sof = sofReq;
   assign linkEvt.hostAck = remain == 5'h01 && !tmoMode;
   assign linkEvt.hostTimeout = remain == 5'h01 && tmoMode;
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the IN endpoint control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import usb_in_ep_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tok = 1'b0, sof = 1'b0, iso = 1'b0, tmo = 1'b0;
   logic [7:0] adr = 8'h00, q, v;
   logic [3:0] sel = 4'hF, dly = 4'h0;
   logic [31:0] dat = 32'h0, datO;
   logic ack, tog, irq, ptrRst, split, isIn, busy, upHalf, loHalf;
   logic mReady = 1'b0, mUnder = 1'b0, mTog = 1'b0;
   link_evt_t linkEvt;
   link_cmd_t linkCmd;
   int num_errors = 0, comparisons = 0, irqSeen = 0, ptrSeen = 0, mCount = 0, mIrq = 0;
   logic [7:0] adrs [4] = '{8'h44, 8'h48, 8'h4C, 8'h50};
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (irq === 1'b1) irqSeen++;
      if (ptrRst === 1'b1) ptrSeen++;
   end
   usb_in_endpoint_control dut_u (.core_clk, .rst_n, .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ack), .linkEvt, .linkCmd,
      .dataToggle(tog), .epIrq(irq), .fifoPtrReset(ptrRst), .fifoSplit(split),
      .endpointIsIn(isIn), .inUpperHalf(upHalf), .outLowerHalf(loHalf));
   usb_host_model host_u (.core_clk, .rst_n, .tokReq(tok), .sofReq(sof), .isoMode(iso),
      .tmoMode(tmo), .ackDelay(dly), .linkCmd, .linkEvt, .busy);
   // ==========
   // Tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      r = $urandom();
      repeat (2) @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a[7:2], r[1:0]};
      dat <= {r[31:8], d};
      @(posedge core_clk);
      while (ack !== 1'b1) @(posedge core_clk);
      q = datO[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk("register", e, q);
   endtask
   function automatic logic [7:0] lowExp();
      return {5'h0, mUnder, mCount != 0, mReady};
   endfunction
   task automatic token(input logic [2:0] e);
      @(posedge core_clk);
      tok <= 1'b1;
      @(posedge core_clk);
      tok <= 1'b0;
      @(posedge core_clk);
      chk("linkCmd", {5'h0, e}, {5'h0, linkCmd});
      @(posedge core_clk);
      while (busy === 1'b1) @(posedge core_clk);
   endtask
   task automatic summarize();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      summarize();
   end
   // ==========
   // Scenarios
   initial begin
      void'($urandom(32'hE76F));
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (adrs[i]) rd(adrs[i], (i == 3) ? 8'h08 : 8'h00);
      bus(1'b1, 8'h7C, 8'hFF);
      rd(8'h7C, 8'h00);
      repeat (4) begin
         v = 8'($urandom());
         bus(1'b1, 8'h48, v);
         rd(8'h48, v & 8'hEC);
         chk("split", {7'h0, v[2]}, {7'h0, split});
         chk("dirIn", {7'h0, v[2] | v[5]}, {7'h0, isIn});
         chk("halves", {6'h0, v[2], v[2]}, {6'h0, upHalf, loHalf});
      end
      bus(1'b1, 8'h48, 8'h00);
      bus(1'b1, 8'h4C, 8'h02);
      token(3'b001);
      mUnder = 1;
      for (int f = 0; f < 2; f++) for (int t = 0; t < 2; t++) begin
         bus(1'b1, 8'h48, 8'(f << 3));
         bus(1'b1, 8'h44, 8'h05);
         mCount = 1;
         mReady = 1;
         rd(8'h44, lowExp());
         dly <= 4'($urandom_range(0, 9));
         tmo <= 1'(t);
         token(3'b100);
         if (t) begin
            tmo <= 1'b0;
            token(3'b100);
            mTog ^= 1'(f);
         end
         mTog = ~mTog;
         mCount = 0;
         mReady = 0;
         mIrq++;
         rd(8'h50, {5'h01, 2'h0, mTog});
         chk("dataToggle", {7'h0, mTog}, {7'h0, tog});
         rd(8'h44, lowExp());
         chk("irqCount", 8'(mIrq), 8'(irqSeen));
      end
      bus(1'b1, 8'h44, 8'h40);
      mTog = 0;
      mUnder = 0;
      rd(8'h44, lowExp());
      rd(8'h50, 8'h08);
      bus(1'b1, 8'h48, 8'h80);
      bus(1'b1, 8'h44, 8'h01);
      mCount = 1;
      rd(8'h44, lowExp());
      bus(1'b1, 8'h44, 8'h01);
      mCount = 2;
      mReady = 1;
      rd(8'h44, lowExp());
      repeat (2) begin
         bus(1'b1, 8'h44, 8'h08);
         mCount--;
         mReady = 0;
         rd(8'h44, lowExp());
      end
      chk("ptrResets", 8'h02, 8'(ptrSeen));
      bus(1'b1, 8'h48, 8'h40);
      iso <= 1'b1;
      token(3'b010);
      mUnder = 1;
      rd(8'h44, lowExp());
      bus(1'b1, 8'h44, 8'h00);
      bus(1'b1, 8'h4C, 8'h03);
      bus(1'b1, 8'h44, 8'h01);
      mUnder = 0;
      mCount = 1;
      rd(8'h44, lowExp());
      @(posedge core_clk);
      sof <= 1'b1;
      @(posedge core_clk);
      sof <= 1'b0;
      mReady = 1;
      rd(8'h44, lowExp());
      token(3'b100);
      mCount = 0;
      mReady = 0;
      mIrq++;
      rd(8'h44, lowExp());
      chk("irqCount", 8'(mIrq), 8'(irqSeen));
      summarize();
   end
endmodule
`default_nettype wire
